// *** rtl/mps_consts.svh ***
// constants of the multichannel programmer status and control block
`ifndef MPS_CONSTS_SVH
`define MPS_CONSTS_SVH
`define MPS_NCH 4
`define MPS_CLK_KHZ 25000
`define MPS_DEBOUNCE_MS 10
`define MPS_BLINK_MS 250
`define MPS_BEEP_MS 100
`define MPS_ALARM_BEEPS 2'h3
`define MPS_OK_BEEPS 2'h1
`define MPS_OFS_CTRL 8'h00
`define MPS_OFS_STATUS 8'h04
`define MPS_OFS_CMD 8'h08
`define MPS_CTRL_RST 9'h00F
`define MPS_CMD_DOWNLOAD 0
`define MPS_CMD_START 1
`define MPS_ST_OFFLINE 8
`define MPS_ST_SELFTEST_ERR 9
`define MPS_ST_TOTAL_BUSY 10
`define MPS_ST_TOTAL_OK 11
`define MPS_ST_BUZZER 12
`define MPS_SYNC_RST 10'h03F
`endif

// *** rtl/mps_pkg.sv ***
// types of the multichannel programmer status and control block
package mps_pkg;
  typedef enum logic [1:0] {
    CH_IDLE = 2'h0,
    CH_BUSY = 2'h1,
    CH_PASS = 2'h2,
    CH_FAIL = 2'h3
  } mps_chan_state_type;
  typedef enum logic [1:0] {
    LINK_FOUR_WIRE = 2'h0,
    LINK_SER_DEBUG = 2'h1,
    LINK_TWO_VENDOR = 2'h2,
    LINK_ONE_VENDOR = 2'h3
  } mps_link_mode_type;
  typedef enum logic [1:0] {
    BZ_IDLE = 2'h0,
    BZ_ON = 2'h1,
    BZ_GAP = 2'h2
  } mps_buzz_state_type;
  typedef struct packed {
    mps_link_mode_type link_mode;
    logic reset_pin_entry_option;
    logic manual;
    logic auto_trig;
    logic [3:0] chan_sel;
  } mps_ctrl_type;
  typedef struct packed {
    logic [3:0] tck;
    logic [3:0] tdi;
    logic [3:0] tms;
    logic [3:0] dio;
    logic [3:0] dio_oe;
    logic [3:0] two_wire_vendor_data;
    logic [3:0] tda_oe;
  } mps_link_out_type;
endpackage

// *** rtl/mps_ctrl.sv ***
// status and control of a four-socket mass-production programmer
`timescale 1ns/1ps
`include "mps_consts.svh"

// Overview of operation
// - four independent channels, all able to program at once.
// - main key starts every selected channel not already busy and no unselected one.
// - main key honoured only online or offline in key mode.
// - key one acts as main key; keys two to four own channel.
// - per-channel green lamp, active high, shows success.
// - per-channel red lamp, active high, shows busy.
// - external start low acts like a main key press.
// - total OK high only while all four channels succeeded.
// - total busy high while any channel is busy.
// - programming channel: red on, green off.
// - successful channel: red off, green on.
// - failed channel: red and green blink together in phase.
// - chip removed: both lamps of that channel off.
// - failed self-test blocks offline work until parameters downloaded.
// - manual mode: one short low beep pass, three short high fail.
// - any single channel failure sounds the alarm.
// - offline mode when powered without USB after a download.
// - offline trigger chosen by configuration: key or auto detect.
// - reset-pin option drives each target reset from channel output.
// - four-wire, serial-debug, two-wire or one-wire links, one mode shared by all channels.
// - key mode starts on key; auto mode starts on chip placed.
module mps_ctrl #(
  parameter int DEB_CYC = `MPS_DEBOUNCE_MS * `MPS_CLK_KHZ,
  parameter int BLINK_CYC = `MPS_BLINK_MS * `MPS_CLK_KHZ,
  parameter int BEEP_CYC = `MPS_BEEP_MS * `MPS_CLK_KHZ
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic start_key_n_i,
  input wire logic ext_start_n_i,
  input wire logic [3:0] chan_key_n_i,
  input wire logic [3:0] chip_present_i,
  input wire logic usb_connected_i,
  input wire logic project_stored_i,
  input wire logic selftest_pass_i,
  input wire logic [3:0] chan_done_i,
  input wire logic [3:0] chan_pass_i,
  input wire logic [3:0] eng_rst_req_i,
  input wire logic [3:0] eng_clk_i,
  input wire logic [3:0] eng_tdi_i,
  input wire logic [3:0] eng_tms_i,
  input wire logic [3:0] eng_dout_i,
  input wire logic [3:0] eng_dout_oe_i,
  output logic [3:0] eng_din_o,
  output logic [3:0] chan_start_o,
  output logic [3:0] chan_busy_lamp_o,
  output logic [3:0] chan_ok_lamp_o,
  output logic [3:0] chan_ok_lamp_alt_o,
  output logic total_busy_o,
  output logic total_ok_o,
  output logic buzzer_o,
  output logic buzzer_high_o,
  output logic selftest_err_o,
  output logic offline_mode_o,
  output logic [3:0] chan_target_reset_n_o,
  output logic [3:0] link_tck_o,
  output logic [3:0] link_tdi_o,
  output logic [3:0] link_tms_o,
  output logic [3:0] link_dio_o,
  output logic [3:0] link_dio_oe_o,
  input wire logic [3:0] link_dio_i,
  output logic [3:0] two_wire_vendor_data_o,
  output logic [3:0] two_wire_vendor_data_oe_o,
  input wire logic [3:0] two_wire_vendor_data_i
);
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int BW = $clog2(BLINK_CYC + 1);
  localparam int ZW = $clog2(BEEP_CYC + 1);
  localparam logic [DW-1:0] DEB_MAX = DW'(DEB_CYC - 1);
  localparam logic [BW-1:0] BLINK_MAX = BW'(BLINK_CYC - 1);
  localparam logic [ZW-1:0] BEEP_MAX = ZW'(BEEP_CYC - 1);

  if (DEB_CYC < 1 || BLINK_CYC < 1 || BEEP_CYC < 1) begin : g_bad_param
    $error("mps_ctrl: cycle counts must be at least one");
  end

  // ----------------------------------------------------------------
  // input synchronisers and debouncers
  // ----------------------------------------------------------------
  logic [9:0] raw_s1_q, raw_s2_q, deb_q, deb_prev_q;
  logic [9:0] act;
  logic [1:0] usb_s_q;
  logic [3:0] dio_s1_q, dio_s2_q, tda_s1_q, tda_s2_q;
  // engine link clock and strobes cross in through two flops
  logic [11:0] eng_s1_q, eng_s2_q;
  logic [DW-1:0] deb_cnt_q [10];

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      raw_s1_q <= `MPS_SYNC_RST;
      raw_s2_q <= `MPS_SYNC_RST;
      usb_s_q <= 2'h0;
      dio_s1_q <= 4'h0;
      dio_s2_q <= 4'h0;
      tda_s1_q <= 4'h0;
      tda_s2_q <= 4'h0;
      eng_s1_q <= 12'h000;
      eng_s2_q <= 12'h000;
      deb_prev_q <= 10'h000;
    end else begin
      raw_s1_q <= {chip_present_i, chan_key_n_i, ext_start_n_i, start_key_n_i};
      raw_s2_q <= raw_s1_q;
      usb_s_q <= {usb_s_q[0], usb_connected_i};
      dio_s1_q <= link_dio_i;
      dio_s2_q <= dio_s1_q;
      tda_s1_q <= two_wire_vendor_data_i;
      tda_s2_q <= tda_s1_q;
      eng_s1_q <= {eng_tms_i, eng_tdi_i, eng_clk_i};
      eng_s2_q <= eng_s1_q;
      deb_prev_q <= deb_q;
    end
  end

  // keys and start input are active low, chip detect active high
  assign act = {raw_s2_q[9:6], ~raw_s2_q[5:0]};

  for (genvar i = 0; i < 10; i++) begin : g_deb
    always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
        deb_q[i] <= 1'b0;
        deb_cnt_q[i] <= '0;
      end else if (act[i] == deb_q[i]) begin
        deb_cnt_q[i] <= '0;
      end else if (deb_cnt_q[i] == DEB_MAX) begin
        deb_q[i] <= act[i];
        deb_cnt_q[i] <= '0;
      end else begin
        deb_cnt_q[i] <= deb_cnt_q[i] + 1'b1;
      end
    end
  end

  wire [9:0] press = deb_q & ~deb_prev_q;
  wire [3:0] placed = press[9:6];
  wire [3:0] removed = deb_prev_q[9:6] & ~deb_q[9:6];
  wire [3:0] key_press = press[5:2];

  // ----------------------------------------------------------------
  // power-up: offline entry and self-test
  // ----------------------------------------------------------------
  logic [1:0] boot_q;
  logic offline_q, st_err_q;
  logic sw_start_q;
  mps_pkg::mps_ctrl_type ctrl_q;
  wire boot_done = (boot_q == 2'h3);

  wire apb_acc = psel_i & penable_i;
  wire apb_setup = psel_i & ~penable_i;
  wire hit_ctrl = (paddr_i == `MPS_OFS_CTRL);
  wire hit_status = (paddr_i == `MPS_OFS_STATUS);
  wire hit_cmd = (paddr_i == `MPS_OFS_CMD);
  wire mapped = hit_ctrl | hit_status | hit_cmd;
  wire wr_ctrl = apb_acc & pwrite_i & hit_ctrl;
  wire wr_cmd = apb_acc & pwrite_i & hit_cmd;
  wire dl_cmd = wr_cmd & pwdata_i[`MPS_CMD_DOWNLOAD];

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      boot_q <= 2'h0;
      offline_q <= 1'b0;
      st_err_q <= 1'b0;
    end else begin
      if (!boot_done) begin
        boot_q <= boot_q + 2'h1;
      end
      if (boot_q == 2'h2) begin
        offline_q <= ~usb_s_q[1] & project_stored_i;
        st_err_q <= ~selftest_pass_i;
      end else if (dl_cmd) begin
        st_err_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // start decision
  // ----------------------------------------------------------------
  wire offline_ok = boot_done & offline_q & ~st_err_q;
  wire key_mode = (boot_done & ~offline_q) | (offline_ok & ~ctrl_q.auto_trig);
  wire auto_mode = offline_ok & ctrl_q.auto_trig;
  wire main_req = press[0] | press[1] | key_press[0] | sw_start_q;
  wire main_go = key_mode & main_req;

  mps_pkg::mps_chan_state_type st_q [4];
  logic [3:0] go, busy, pass, fail_evt, pass_evt;

  for (genvar n = 0; n < 4; n++) begin : g_chan
    wire own_key = (n > 0) & key_press[n];
    assign go[n] = ctrl_q.chan_sel[n]
      & (main_go | (key_mode & own_key) | (auto_mode & placed[n]));
    assign busy[n] = (st_q[n] == mps_pkg::CH_BUSY);
    assign pass[n] = (st_q[n] == mps_pkg::CH_PASS);
    assign fail_evt[n] = busy[n] & chan_done_i[n] & ~chan_pass_i[n];
    assign pass_evt[n] = busy[n] & chan_done_i[n] & chan_pass_i[n];

    // independent channel state, removal wins over result
    always_ff @(posedge sys_clk_i) begin
      if (!nrst_i) begin
        st_q[n] <= mps_pkg::CH_IDLE;
        chan_start_o[n] <= 1'b0;
      end else begin
        chan_start_o[n] <= go[n] & ~busy[n];
        if (removed[n]) begin
          st_q[n] <= mps_pkg::CH_IDLE;
        end else if (fail_evt[n]) begin
          st_q[n] <= mps_pkg::CH_FAIL;
        end else if (pass_evt[n]) begin
          st_q[n] <= mps_pkg::CH_PASS;
        end else if (go[n] & ~busy[n]) begin
          st_q[n] <= mps_pkg::CH_BUSY;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // lamps
  // ----------------------------------------------------------------
  logic [BW-1:0] blink_cnt_q;
  logic blink_q;
  logic [3:0] red_d, green_d;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_MAX) begin
      blink_cnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  for (genvar n = 0; n < 4; n++) begin : g_lamp
    wire failed = (st_q[n] == mps_pkg::CH_FAIL);
    assign red_d[n] = busy[n] | (failed & blink_q);
    assign green_d[n] = pass[n] | (failed & blink_q);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      chan_busy_lamp_o <= 4'h0;
      chan_ok_lamp_o <= 4'h0;
      chan_ok_lamp_alt_o <= 4'h0;
      total_busy_o <= 1'b0;
      total_ok_o <= 1'b0;
    end else begin
      chan_busy_lamp_o <= red_d;
      chan_ok_lamp_o <= green_d;
      chan_ok_lamp_alt_o <= green_d;
      total_busy_o <= |busy;
      total_ok_o <= &pass;
    end
  end

  // ----------------------------------------------------------------
  // buzzer sequencer
  // ----------------------------------------------------------------
  mps_pkg::mps_buzz_state_type bz_q;
  logic [ZW-1:0] bz_cnt_q;
  logic [1:0] beeps_q;
  wire any_fail = |fail_evt;
  wire ok_beep = (|pass_evt) & ctrl_q.manual & (bz_q == mps_pkg::BZ_IDLE);
  wire bz_tick = (bz_cnt_q == BEEP_MAX);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bz_q <= mps_pkg::BZ_IDLE;
      bz_cnt_q <= '0;
      beeps_q <= 2'h0;
      buzzer_high_o <= 1'b0;
    end else if (any_fail) begin
      bz_q <= mps_pkg::BZ_ON;
      bz_cnt_q <= '0;
      beeps_q <= `MPS_ALARM_BEEPS - 2'h1;
      buzzer_high_o <= 1'b1;
    end else if (ok_beep) begin
      bz_q <= mps_pkg::BZ_ON;
      bz_cnt_q <= '0;
      beeps_q <= `MPS_OK_BEEPS - 2'h1;
      buzzer_high_o <= 1'b0;
    end else begin
      bz_cnt_q <= bz_tick ? '0 : bz_cnt_q + 1'b1;
      case (bz_q)
        mps_pkg::BZ_ON: begin
          if (bz_tick) begin
            bz_q <= (beeps_q == 2'h0) ? mps_pkg::BZ_IDLE : mps_pkg::BZ_GAP;
          end
        end
        mps_pkg::BZ_GAP: begin
          if (bz_tick) begin
            bz_q <= mps_pkg::BZ_ON;
            beeps_q <= beeps_q - 2'h1;
          end
        end
        default: begin
          bz_q <= mps_pkg::BZ_IDLE;
          bz_cnt_q <= '0;
        end
      endcase
    end
  end

  assign buzzer_o = (bz_q == mps_pkg::BZ_ON);
  assign selftest_err_o = st_err_q;
  assign offline_mode_o = offline_q;

  // ----------------------------------------------------------------
  // target links and reset pins
  // ----------------------------------------------------------------
  mps_pkg::mps_link_out_type lk_d, lk_q;
  mps_pkg::mps_link_mode_type lm;
  assign lm = ctrl_q.link_mode;

  for (genvar n = 0; n < 4; n++) begin : g_link
    wire four = (lm == mps_pkg::LINK_FOUR_WIRE);
    wire two_v = (lm == mps_pkg::LINK_TWO_VENDOR);
    wire dio_drv = (lm == mps_pkg::LINK_SER_DEBUG) | (lm == mps_pkg::LINK_ONE_VENDOR);
    assign lk_d.tck[n] = (lm != mps_pkg::LINK_ONE_VENDOR) & eng_s2_q[n];
    assign lk_d.tdi[n] = four & eng_s2_q[4+n];
    assign lk_d.tms[n] = four & eng_s2_q[8+n];
    assign lk_d.dio[n] = dio_drv & eng_dout_i[n];
    assign lk_d.dio_oe[n] = dio_drv & eng_dout_oe_i[n];
    assign lk_d.two_wire_vendor_data[n] = two_v & eng_dout_i[n];
    assign lk_d.tda_oe[n] = two_v & eng_dout_oe_i[n];
    assign eng_din_o[n] = two_v ? tda_s2_q[n] : dio_s2_q[n];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      lk_q <= '0;
      chan_target_reset_n_o <= 4'hF;
    end else begin
      lk_q <= lk_d;
      chan_target_reset_n_o <= ~({4{ctrl_q.reset_pin_entry_option}} & eng_rst_req_i);
    end
  end

  assign link_tck_o = lk_q.tck;
  assign link_tdi_o = lk_q.tdi;
  assign link_tms_o = lk_q.tms;
  assign link_dio_o = lk_q.dio;
  assign link_dio_oe_o = lk_q.dio_oe;
  assign two_wire_vendor_data_o = lk_q.two_wire_vendor_data;
  assign two_wire_vendor_data_oe_o = lk_q.tda_oe;

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  wire [31:0] status_word = {19'h00000, buzzer_o, total_ok_o, total_busy_o, st_err_q,
    offline_q, st_q[3], st_q[2], st_q[1], st_q[0]};
  wire [31:0] rd_word = hit_ctrl ? {23'h000000, ctrl_q} : hit_status ? status_word : 32'h0;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ctrl_q <= `MPS_CTRL_RST;
      sw_start_q <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i[8:0];
      end
      sw_start_q <= wr_cmd & pwdata_i[`MPS_CMD_START];
      if (apb_setup) begin
        prdata_o <= rd_word;
      end
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc & ~mapped;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  for (genvar n = 0; n < 4; n++) begin : g_chk
    property p_busy_lamps;
      busy[n] |=> chan_busy_lamp_o[n] && !chan_ok_lamp_o[n];
    endproperty
    a_busy_lamps: assert property (p_busy_lamps) else $error("busy lamps wrong");
    property p_pass_lamps;
      pass[n] |=> !chan_busy_lamp_o[n] && chan_ok_lamp_o[n] && chan_ok_lamp_alt_o[n];
    endproperty
    a_pass_lamps: assert property (p_pass_lamps) else $error("pass lamps wrong");
    property p_fail_phase;
      (st_q[n] == mps_pkg::CH_FAIL) |=> chan_busy_lamp_o[n] == chan_ok_lamp_o[n];
    endproperty
    a_fail_phase: assert property (p_fail_phase) else $error("fail blink out of phase");
    property p_removed;
      removed[n] |=> (st_q[n] == mps_pkg::CH_IDLE) ##1 !chan_busy_lamp_o[n] && !chan_ok_lamp_o[n];
    endproperty
    a_removed: assert property (p_removed) else $error("removed chip lamps not off");
  end

  property p_no_unsel;
    (chan_start_o & ~$past(ctrl_q.chan_sel)) == 4'h0;
  endproperty
  a_no_unsel: assert property (p_no_unsel) else $error("unselected channel started");
  property p_key_ignored;
    auto_mode && main_req && !(|placed) |=> chan_start_o == 4'h0;
  endproperty
  a_key_ignored: assert property (p_key_ignored) else $error("key honoured in auto mode");
  property p_total;
    ##1 (total_ok_o == $past(&pass)) && (total_busy_o == $past(|busy));
  endproperty
  a_total: assert property (p_total) else $error("total lamps wrong");
  property p_selftest;
    st_err_q && offline_q |-> !key_mode && !auto_mode;
  endproperty
  a_selftest: assert property (p_selftest) else $error("offline start after failed self-test");
  property p_alarm;
    any_fail |=> buzzer_o && buzzer_high_o && beeps_q == 2'h2;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not started");
  property p_ok_beep;
    ok_beep && !any_fail |=> buzzer_o && !buzzer_high_o && beeps_q == 2'h0;
  endproperty
  a_ok_beep: assert property (p_ok_beep) else $error("ok beep wrong");

  c_main_start: cover property (main_go ##1 chan_start_o == ctrl_q.chan_sel);
  c_fail_alarm: cover property (any_fail ##1 buzzer_o);
  c_all_ok: cover property (total_ok_o);
  c_auto_start: cover property (auto_mode && |placed);
endmodule

// *** test/mps_target_model.sv ***
// engine and target stand-in behind the four sockets
`timescale 1ns/1ps
module mps_target_model #(
  parameter int LAT = 40
) (
  input wire logic clk_i,
  input wire logic [3:0] start_i,
  input wire logic [3:0] pass_mask_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] drv_i,
  output logic [3:0] done_o,
  output logic [3:0] pass_o,
  output logic [7:0] wire_o
);
  int cnt [4] = '{0, 0, 0, 0};
  logic [7:0] pat_q = 8'h5A;
  initial begin
    done_o = 4'h0;
    pass_o = 4'h0;
  end
  // one result pulse per started channel, LAT cycles later
  always @(posedge clk_i) begin
    pat_q <= ~pat_q;
    for (int i = 0; i < 4; i++) begin
      done_o[i] <= (cnt[i] == 1);
      pass_o[i] <= pass_mask_i[i];
      if (start_i[i]) begin
        cnt[i] <= LAT;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  // released line shows a toggling pattern, never a held value
  assign wire_o = (oe_i & drv_i) | (~oe_i & pat_q);
endmodule

// *** test/mps_ctrl_test.sv ***
// self-checking bench of the programmer status and control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH %0t observed %h expected %h", $time, a, b); end end
module mps_ctrl_test;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lclk = 1'b0, lrun = 1'b1, usb = 1'b1, proj = 1'b1, stp = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, tbusy, tok, buz, buzhi, st_err, offl, buz_q = 1'b0, hi_seen = 1'b0;
  logic [5:0] keys_n = 6'h3F;
  logic [3:0] chips = 4'hF, pmask = 4'hF, rst_req = 4'h0, dout = 4'h9, doe = 4'h0;
  logic [3:0] start, busy_l, ok_l, ok_alt, done, pass, trst_n, tck, dio, dio_oe, two_wire_vendor_data, tda_oe;
  logic [3:0] din, tdi, tms;
  logic [7:0] lwire;
  int err_count = 0, checks = 0, beeps = 0;
  always #20 clk = ~clk;
  always #160 if (lrun) lclk = ~lclk;
  // ---------------------------------------------------------------
  // design and far side
  // ---------------------------------------------------------------
  mps_ctrl #(.DEB_CYC(4), .BLINK_CYC(16), .BEEP_CYC(8)) dut (
    .sys_clk_i(clk), .nrst_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .start_key_n_i(keys_n[4]), .ext_start_n_i(keys_n[5]),
    .chan_key_n_i(keys_n[3:0]), .chip_present_i(chips), .usb_connected_i(usb),
    .project_stored_i(proj), .selftest_pass_i(stp), .chan_done_i(done), .chan_pass_i(pass),
    .eng_rst_req_i(rst_req), .eng_clk_i({4{lclk}}), .eng_tdi_i({4{~lclk}}),
    .eng_tms_i({4{lclk}}), .eng_dout_i(dout), .eng_dout_oe_i(doe), .eng_din_o(din),
    .chan_start_o(start), .chan_busy_lamp_o(busy_l), .chan_ok_lamp_o(ok_l),
    .chan_ok_lamp_alt_o(ok_alt), .total_busy_o(tbusy), .total_ok_o(tok), .buzzer_o(buz),
    .buzzer_high_o(buzhi), .selftest_err_o(st_err), .offline_mode_o(offl),
    .chan_target_reset_n_o(trst_n), .link_tck_o(tck), .link_tdi_o(tdi), .link_tms_o(tms),
    .link_dio_o(dio), .link_dio_oe_o(dio_oe), .link_dio_i(lwire[3:0]),
    .two_wire_vendor_data_o(two_wire_vendor_data), .two_wire_vendor_data_oe_o(tda_oe),
    .two_wire_vendor_data_i(lwire[7:4]));
  mps_target_model model (.clk_i(clk), .start_i(start), .pass_mask_i(pmask),
    .oe_i({tda_oe, dio_oe}), .drv_i({two_wire_vendor_data, dio}), .done_o(done), .pass_o(pass), .wire_o(lwire));
  always @(posedge clk) begin
    buz_q <= buz;
    if (buz && !buz_q) beeps <= beeps + 1;
    if (buz && buzhi) hi_seen <= 1'b1;
  end
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic u, input logic p, input logic s);
    @(posedge clk);
    usb <= u; proj <= p; stp <= s; rst_n <= 1'b0;
    cyc(1);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(8);
  endtask
  // holds keys low, collects starts and counts cycles that carry a start pulse
  task automatic press(input logic [5:0] m, output logic [3:0] s, output int n);
    s = 4'h0;
    n = 0;
    @(posedge clk);
    keys_n <= ~m;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      if (i == 12) keys_n <= 6'h3F;
      #1;
      s |= start;
      n += (start != 4'h0);
    end
  endtask
  task automatic replug(output logic [3:0] s);
    @(posedge clk);
    chips <= 4'h0;
    cyc(12);
    `CHK({busy_l, ok_l}, 8'h00)
    @(posedge clk);
    chips <= 4'hF;
    s = 4'h0;
    repeat (30) begin
      cyc(1);
      s |= start;
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_boot();
    logic [31:0] r;
    logic e;
    do_reset(1'b1, 1'b1, 1'b1);
    `CHK({trst_n, offl, busy_l, ok_l}, {4'hF, 1'b0, 8'h00})
    apb(1'b0, 8'h00, 32'h0, r, e);
    `CHK({e, r}, {1'b0, 32'h0000_000F})
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, r, e);
    `CHK(e, 1'b1)
    apb(1'b0, 8'h0C, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
  endtask
  task automatic t_main();
    logic [31:0] r;
    logic e;
    logic [3:0] s;
    int n;
    apb(1'b1, 8'h00, 32'h0000_0025, r, e);
    beeps = 0;
    hi_seen = 1'b0;
    press(6'h10, s, n);
    `CHK(s, 4'h5)
    `CHK(n, 1)
    `CHK({busy_l, ok_l, tbusy}, {4'h5, 4'h0, 1'b1})
    cyc(60);
    `CHK({busy_l, ok_l, tbusy, tok}, {4'h0, 4'h5, 2'b00})
    apb(1'b0, 8'h04, 32'h0, r, e);
    `CHK(r[7:0], 8'h22)
    `CHK({beeps, hi_seen}, {32'd1, 1'b0})
  endtask
  task automatic t_all();
    logic [31:0] r;
    logic e;
    logic [3:0] s;
    int n;
    replug(s);
    `CHK(s, 4'h0)
    apb(1'b1, 8'h00, 32'h0000_000F, r, e);
    beeps = 0;
    press(6'h20, s, n);
    `CHK(s, 4'hF)
    cyc(60);
    `CHK({tok, ok_l, ok_alt, busy_l}, {1'b1, 4'hF, 4'hF, 4'h0})
    `CHK(beeps, 0)
    // software start acts as the main key on every selected channel
    apb(1'b1, 8'h08, 32'h0000_0002, r, e);
    cyc(1);
    `CHK(start, 4'hF)
  endtask
  task automatic t_fail();
    logic [3:0] s;
    int n, bad, ones, zeros;
    replug(s);
    @(posedge clk);
    pmask <= 4'hD;
    beeps = 0;
    hi_seen = 1'b0;
    press(6'h02, s, n);
    `CHK({s, busy_l, tbusy, tok}, {4'h2, 4'h2, 2'b10})
    press(6'h01, s, n);
    `CHK(s, 4'hD)
    cyc(60);
    bad = 0; ones = 0; zeros = 0;
    repeat (70) begin
      cyc(1);
      bad += (busy_l[1] !== ok_l[1]);
      ones += (busy_l[1] === 1'b1);
      zeros += (busy_l[1] === 1'b0);
    end
    `CHK({bad == 0, ones > 0, zeros > 0}, 3'b111)
    `CHK({beeps, hi_seen, tok}, {32'd3, 2'b10})
  endtask
  task automatic t_link();
    logic [31:0] r;
    logic e;
    @(posedge clk);
    lrun <= 1'b0;
    rst_req <= 4'h3;
    doe <= 4'hF;
    apb(1'b1, 8'h00, 32'h0000_004F, r, e);
    cyc(6);
    `CHK({tck, trst_n}, {{4{lclk}}, 4'hC})
    `CHK({tdi, tms, dio_oe, tda_oe}, {{4{~lclk}}, {4{lclk}}, 8'h00})
    apb(1'b1, 8'h00, 32'h0000_008F, r, e);
    cyc(4);
    `CHK({tck, trst_n}, {{4{lclk}}, 4'hF})
    `CHK({dio, dio_oe, tda_oe, din}, {4'h9, 4'hF, 4'h0, 4'h9})
    apb(1'b1, 8'h00, 32'h0000_010F, r, e);
    cyc(4);
    `CHK({tck, two_wire_vendor_data, tda_oe, dio_oe, din}, {{4{lclk}}, 4'h9, 4'hF, 4'h0, 4'h9})
    apb(1'b1, 8'h00, 32'h0000_018F, r, e);
    cyc(4);
    `CHK({tck, tdi, dio, dio_oe, din}, {4'h0, 4'h0, 4'h9, 4'hF, 4'h9})
    @(posedge clk);
    lrun <= 1'b1;
    rst_req <= 4'h0;
    doe <= 4'h0;
  endtask
  task automatic t_offline();
    logic [31:0] r;
    logic e;
    logic [3:0] s;
    int n;
    do_reset(1'b0, 1'b1, 1'b0);
    `CHK({offl, st_err}, 2'b11)
    press(6'h10, s, n);
    `CHK(s, 4'h0)
    apb(1'b1, 8'h08, 32'h0000_0001, r, e);
    cyc(2);
    `CHK(st_err, 1'b0)
    press(6'h10, s, n);
    `CHK(s, 4'hF)
    cyc(60);
    apb(1'b1, 8'h00, 32'h0000_001F, r, e);
    press(6'h10, s, n);
    `CHK(s, 4'h0)
    replug(s);
    `CHK(s, 4'hF)
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  initial begin
    t_boot();
    t_main();
    t_all();
    t_fail();
    t_link();
    t_offline();
    complete_run();
  end
endmodule
